// *** sgq_cfg.svh ***
// register offsets, field positions, reset values, descriptor word indices and response codes of the descriptor queue control block
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register
`ifndef SGQ_CFG_SVH
`define SGQ_CFG_SVH
`define SGQ_OFF_CTRL 12'h000
`define SGQ_OFF_STATUS 12'h004
`define SGQ_OFF_CUR_LO 12'h008
`define SGQ_OFF_CUR_HI 12'h00C
`define SGQ_OFF_TAIL_LO 12'h010
`define SGQ_OFF_TAIL_HI 12'h014
`define SGQ_OFF_DROP 12'h018
`define SGQ_OFF_PROC 12'h01C
`define SGQ_OFF_SIDEBAND 12'h4B0
`define SGQ_BIT_RUN 0
`define SGQ_BIT_EMPTY 0
`define SGQ_BIT_SHORT 1
`define SGQ_PTR_LSB 6
`define SGQ_SB_RESET 32'h0003_0003
`define SGQ_SB_MASK 32'h0F0F_0F0F
`define SGQ_BASE_WORDS 8
`define SGQ_APP_WORDS 5
`define SGQ_W_NEXT_LO 4'h0
`define SGQ_W_NEXT_HI 4'h1
`define SGQ_W_BUF_LO 4'h2
`define SGQ_W_BUF_HI 4'h3
`define SGQ_W_CTRL 4'h5
`define SGQ_W_SIX 4'h6
`define SGQ_W_SEVEN 4'h7
`define SGQ_RESP_OKAY 2'h0
`define SGQ_RESP_DECERR 2'h3
`endif

// *** sgq_pkg.sv ***
// types shared by the descriptor queue control block
// the offsets and figures live in sgq_cfg.svh
package sgq_pkg;
  // fetch engine states
  typedef enum logic [1:0] {SGQ_IDLE, SGQ_ADDR, SGQ_DATA, SGQ_HOLD} sgq_state_t;
  // sideband settings of the descriptor port
  typedef struct packed {
    logic [3:0] awuser;
    logic [3:0] awcache;
    logic [3:0] aruser;
    logic [3:0] arcache;
  } sgq_sideband_t;
  // fetched descriptor as handed to the data mover
  typedef struct packed {
    logic [63:0] buf_addr;
    logic [31:0] ctrl;
    logic [31:0] word6;
    logic [31:0] word7;
  } sgq_desc_t;
endpackage

// *** sgq_ctrl.sv ***
// scatter-gather descriptor queue control for one channel: registers, chain walk and packet statistics
// assumes an AXI4-Lite master for registers, AXI4 memory for descriptor reads and a data mover
// that pulses packet arrival, packet completion and descriptor completion on CLOCK_I
`timescale 1ns/100ps
`include "sgq_cfg.svh"

// Notes on behaviour
// R1: shortfall set when queue empties mid-packet
// R2: shortfall clears once packet's last beat placed
// R3: queue-empty reads 1 after reset, set at tail
// R4: tail write restarts fetching, ending queue-empty
// R5: packet arriving on empty queue is dropped
// R6: current pointer bits 31:6, locked while running
// R7: upper current word exists only for wide addresses
// R8: fetching stops after tail descriptor completes
// R9: running and idle: tail write starts fetch
// R10: not running: tail write only moves pause
// R11: upper tail word write also triggers fetch when wide
// R12: drop counter 16 bits, wraps, clears on read
// R13: processed counter 16 bits, rolls, read-safe
// R14: sideband register drives cache/user, caches reset 3
// R15: software programs sideband only while stopped
// R16: descriptor is eight words plus zero/five
// R17: transmit descriptor word layout
// R18: receive descriptor word layout
// R19: user words fetched only with streams enabled
// R20: descriptors sit on 0x40-byte boundaries
// R21: buffer alignment depends on realignment unit
// R22: upper address words used only when wide
// R23: software never clears run bit once set
// R24: chain walked by reads from current pointer
module sgq_ctrl
  import sgq_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter bit APP_EN = 1'b0,
  parameter bit IS_RX = 1'b0
)(
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic [11:0] S_AWADDR_I,
  input wire logic S_AWVALID_I,
  output logic S_AWREADY_O,
  input wire logic [31:0] S_WDATA_I,
  input wire logic [3:0] S_WSTRB_I,
  input wire logic S_WVALID_I,
  output logic S_WREADY_O,
  output logic [1:0] S_BRESP_O,
  output logic S_BVALID_O,
  input wire logic S_BREADY_I,
  input wire logic [11:0] S_ARADDR_I,
  input wire logic S_ARVALID_I,
  output logic S_ARREADY_O,
  output logic [31:0] S_RDATA_O,
  output logic [1:0] S_RRESP_O,
  output logic S_RVALID_O,
  input wire logic S_RREADY_I,
  output logic [ADDR_W-1:0] M_ARADDR_O,
  output logic [7:0] M_ARLEN_O,
  output logic [2:0] M_ARSIZE_O,
  output logic [1:0] M_ARBURST_O,
  output logic [3:0] M_ARCACHE_O,
  output logic [3:0] M_ARUSER_O,
  output logic M_ARVALID_O,
  input wire logic M_ARREADY_I,
  input wire logic [31:0] M_RDATA_I,
  input wire logic M_RLAST_I,
  input wire logic M_RVALID_I,
  output logic M_RREADY_O,
  output logic [3:0] M_AWCACHE_O,
  output logic [3:0] M_AWUSER_O,
  output sgq_desc_t DESC_O,
  output logic DESC_VALID_O,
  input wire logic DESC_DONE_I,
  input wire logic DESC_ERR_I,
  input wire logic PKT_ARRIVE_I,
  input wire logic PKT_DONE_I,
  output logic PKT_DROP_O
);
  localparam int WORDS = APP_EN ? `SGQ_BASE_WORDS + `SGQ_APP_WORDS : `SGQ_BASE_WORDS;
  localparam bit WIDE = ADDR_W > 32;

  sgq_state_t state; // fetch engine state
  logic run; // channel_run_bit
  logic empty; // queue-empty status
  logic shortfall; // queue_shortfall_flag
  logic pkt_active; // a packet is being serviced
  logic walked; // at least one descriptor fetched since reset
  logic [63:0] cur; // current_pointer
  logic [63:0] tail; // tail_pointer
  logic [63:0] nxt; // next pointer of the descriptor held
  logic [15:0] drop_cnt; // dropped packets
  logic [15:0] proc_cnt; // processed packets
  sgq_sideband_t sband; // descriptor-port sideband settings
  logic [3:0] widx; // word index inside the burst
  logic aw_held, w_held; // write address and data taken
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic wr_go; // register write happens this cycle
  logic rd_go; // register read taken this cycle
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic tail_wr; // a tail word was written
  logic start_fetch; // leave idle and fetch
  logic at_tail; // held descriptor is the tail
  logic drop_now; // packet arrives on empty queue

  // register bus: address and data are taken independently, one write at a time
  assign S_AWREADY_O = !aw_held && !S_BVALID_O;
  assign S_WREADY_O = !w_held && !S_BVALID_O;
  assign wr_go = aw_held && w_held;
  assign S_ARREADY_O = !S_RVALID_O;
  assign rd_go = S_ARVALID_I && S_ARREADY_O;

  // capture write address and data as they arrive
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
    end
    else
    begin
      if (S_AWVALID_I && S_AWREADY_O)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AWADDR_I;
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (S_WVALID_I && S_WREADY_O)
      begin
        w_held <= 1'b1;
        w_data <= S_WDATA_I;
      end
      else if (wr_go)
        w_held <= 1'b0;
    end
  end

  // write response, one cycle after both halves are in
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      S_BVALID_O <= 1'b0;
      S_BRESP_O <= `SGQ_RESP_OKAY;
    end
    else if (wr_go)
    begin
      S_BVALID_O <= 1'b1;
      case (aw_addr)
        `SGQ_OFF_CTRL, `SGQ_OFF_CUR_LO, `SGQ_OFF_CUR_HI, `SGQ_OFF_TAIL_LO, `SGQ_OFF_TAIL_HI,
        `SGQ_OFF_SIDEBAND, `SGQ_OFF_STATUS, `SGQ_OFF_DROP, `SGQ_OFF_PROC:
          S_BRESP_O <= `SGQ_RESP_OKAY;
        default:
          S_BRESP_O <= `SGQ_RESP_DECERR; // unmapped word
      endcase
    end
    else if (S_BREADY_I)
      S_BVALID_O <= 1'b0;
  end

  // byte-lane merge; writes carry full words in practice, strobes honoured for the run bit and the sideband word only
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (st[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  logic [3:0] w_strb;
  // strobes are sampled with the data beat
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
      w_strb <= 4'h0;
    else if (S_WVALID_I && S_WREADY_O)
      w_strb <= S_WSTRB_I;
  end

  // sideband word with the write merged over the current fields, so a partial write keeps the rest
  logic [31:0] sb_word;
  assign sb_word = merge({4'h0, sband.awuser, 4'h0, sband.awcache, 4'h0, sband.aruser, 4'h0, sband.arcache},
                         w_data, w_strb);

  // run bit and sideband settings; the sideband is meant to be set while stopped (see R15)
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      run <= 1'b0;
      sband <= sgq_sideband_t'(16'h0303); // see R14
    end
    else if (wr_go)
    begin
      if (aw_addr == `SGQ_OFF_CTRL && w_strb[0])
        run <= w_data[`SGQ_BIT_RUN]; // clearing while running is left to software (see R23)
      if (aw_addr == `SGQ_OFF_SIDEBAND)
        sband <= {sb_word[27:24], sb_word[19:16], sb_word[11:8], sb_word[3:0]}; // see R14
    end
  end

  assign tail_wr = wr_go && (aw_addr == `SGQ_OFF_TAIL_LO || (WIDE && aw_addr == `SGQ_OFF_TAIL_HI)); // see R11
  assign at_tail = (cur == tail);
  assign start_fetch = tail_wr && run && state == SGQ_IDLE; // see R9 R10
  assign drop_now = PKT_ARRIVE_I && empty && !pkt_active;

  // tail pointer stays writable at all times (see R8)
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
      tail <= 64'h0;
    else if (wr_go && aw_addr == `SGQ_OFF_TAIL_LO)
      tail[31:0] <= {w_data[31:`SGQ_PTR_LSB], 6'h00};
    else if (wr_go && WIDE && aw_addr == `SGQ_OFF_TAIL_HI)
      tail[63:32] <= w_data; // see R22
  end

  // current pointer: software owns it while stopped, the engine while running
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
      cur <= 64'h0;
    else if (!run && wr_go && aw_addr == `SGQ_OFF_CUR_LO)
      cur[31:0] <= {w_data[31:`SGQ_PTR_LSB], 6'h00}; // see R6
    else if (!run && wr_go && WIDE && aw_addr == `SGQ_OFF_CUR_HI)
      cur[63:32] <= w_data; // see R7
    else if (start_fetch && walked && empty)
      cur <= nxt; // resume past the old tail
    else if (state == SGQ_HOLD && DESC_DONE_I && !DESC_ERR_I && !at_tail)
      cur <= nxt; // see R24; on error cur keeps the faulty descriptor (see R6)
  end

  // chain walk: read one descriptor, hand it over, follow the next pointer until the tail or a descriptor error
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      state <= SGQ_IDLE;
      widx <= 4'h0;
      walked <= 1'b0;
    end
    else
    begin
      case (state)
        SGQ_IDLE:
          if (start_fetch) // see R4 R9
            state <= SGQ_ADDR;
        SGQ_ADDR:
          if (M_ARREADY_I)
          begin
            state <= SGQ_DATA;
            widx <= 4'h0;
          end
        SGQ_DATA:
          if (M_RVALID_I)
          begin
            widx <= widx + 4'h1;
            if (M_RLAST_I)
            begin
              state <= SGQ_HOLD;
              walked <= 1'b1;
            end
          end
        SGQ_HOLD:
          if (DESC_DONE_I)
            state <= (at_tail || DESC_ERR_I) ? SGQ_IDLE : SGQ_ADDR; // see R8
        default:
          state <= SGQ_IDLE;
      endcase
    end
  end

  // descriptor read port; burst length covers user words only when streams exist
  assign M_ARVALID_O = (state == SGQ_ADDR);
  assign M_ARADDR_O = cur[ADDR_W-1:0]; // see R24 R20
  assign M_ARLEN_O = 8'(WORDS - 1); // see R16 R19
  assign M_ARSIZE_O = 3'h2;
  assign M_ARBURST_O = 2'h1;
  assign M_RREADY_O = (state == SGQ_DATA);
  assign M_ARCACHE_O = sband.arcache; // see R14
  assign M_ARUSER_O = sband.aruser;
  assign M_AWCACHE_O = sband.awcache;
  assign M_AWUSER_O = sband.awuser;
  assign DESC_VALID_O = (state == SGQ_HOLD);

  // unpack descriptor words; upper words only matter for wide addresses (see R17 R18 R22)
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      nxt <= 64'h0;
      DESC_O <= '0;
    end
    else if (state == SGQ_DATA && M_RVALID_I)
    begin
      case (widx)
        `SGQ_W_NEXT_LO: nxt[31:0] <= {M_RDATA_I[31:`SGQ_PTR_LSB], 6'h00};
        `SGQ_W_NEXT_HI: nxt[63:32] <= WIDE ? M_RDATA_I : 32'h0;
        `SGQ_W_BUF_LO: DESC_O.buf_addr[31:0] <= M_RDATA_I; // alignment is software's duty (see R21)
        `SGQ_W_BUF_HI: DESC_O.buf_addr[63:32] <= WIDE ? M_RDATA_I : 32'h0;
        `SGQ_W_CTRL: DESC_O.ctrl <= M_RDATA_I;
        `SGQ_W_SIX: DESC_O.word6 <= M_RDATA_I; // tx sideband control, rx status
        `SGQ_W_SEVEN: DESC_O.word7 <= M_RDATA_I; // tx status, rx sideband status
        default: ; // reserved word and user words pass unused
      endcase
    end
  end

  // queue-empty: set on reaching the tail, cleared by a restart
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
      empty <= 1'b1; // see R3
    else if (state == SGQ_HOLD && DESC_DONE_I && at_tail)
      empty <= 1'b1; // see R3
    else if (start_fetch)
      empty <= 1'b0; // see R4
  end

  // packet tracking and shortfall; a packet that finds the queue empty is thrown away
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      pkt_active <= 1'b0;
      shortfall <= 1'b0;
    end
    else
    begin
      if (PKT_ARRIVE_I && !empty)
        pkt_active <= 1'b1;
      else if (PKT_DONE_I)
        pkt_active <= 1'b0;
      if (pkt_active && empty && !PKT_DONE_I)
        shortfall <= 1'b1; // see R1
      else if (PKT_DONE_I)
        shortfall <= 1'b0; // see R2
    end
  end

  assign PKT_DROP_O = drop_now; // see R5

  // statistics; a drop in the cycle of a clearing read survives as a count of one
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      drop_cnt <= 16'h0000;
      proc_cnt <= 16'h0000;
    end
    else
    begin
      if (rd_go && S_ARADDR_I == `SGQ_OFF_DROP)
        drop_cnt <= drop_now ? 16'h0001 : 16'h0000; // see R12
      else if (drop_now)
        drop_cnt <= drop_cnt + 16'h0001; // see R12
      if (PKT_DONE_I && pkt_active)
        proc_cnt <= proc_cnt + 16'h0001; // see R13
    end
  end

  // read mux
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = `SGQ_RESP_OKAY;
    case (S_ARADDR_I)
      `SGQ_OFF_CTRL: next_rdata[`SGQ_BIT_RUN] = run;
      `SGQ_OFF_STATUS: next_rdata = {30'h0, shortfall, empty};
      `SGQ_OFF_CUR_LO: next_rdata = {cur[31:`SGQ_PTR_LSB], 6'h00};
      `SGQ_OFF_CUR_HI: next_rdata = WIDE ? cur[63:32] : 32'h0;
      `SGQ_OFF_TAIL_LO: next_rdata = tail[31:0];
      `SGQ_OFF_TAIL_HI: next_rdata = WIDE ? tail[63:32] : 32'h0;
      `SGQ_OFF_DROP: next_rdata = {16'h0000, drop_cnt};
      `SGQ_OFF_PROC: next_rdata = {16'h0000, proc_cnt};
      `SGQ_OFF_SIDEBAND: next_rdata = {4'h0, sband.awuser, 4'h0, sband.awcache, 4'h0, sband.aruser,
                                       4'h0, sband.arcache};
      default: next_rresp = `SGQ_RESP_DECERR;
    endcase
  end

  // read data register; answer one cycle after the address is taken
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      S_RVALID_O <= 1'b0;
      S_RDATA_O <= 32'h0000_0000;
      S_RRESP_O <= `SGQ_RESP_OKAY;
    end
    else if (rd_go)
    begin
      S_RVALID_O <= 1'b1;
      S_RDATA_O <= next_rdata;
      S_RRESP_O <= next_rresp;
    end
    else if (S_RREADY_I)
      S_RVALID_O <= 1'b0;
  end

  // checks
  empty_reset_a: assert property (@(posedge CLOCK_I) $rose(RESETN_I) |-> empty) // see R3
    else $error("queue empty not set after reset");
  tail_stop_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    state == SGQ_HOLD && DESC_DONE_I && at_tail |=> state == SGQ_IDLE && empty) // see R8
    else $error("engine did not stop at tail");
  tail_start_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    start_fetch |=> !empty ##0 state == SGQ_ADDR) // see R4
    else $error("tail write did not restart fetch");
  stopped_nofetch_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    !run && state == SGQ_IDLE |=> state == SGQ_IDLE) // see R10
    else $error("fetch started while not running");
  drop_count_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    drop_now && !(rd_go && S_ARADDR_I == `SGQ_OFF_DROP) |=> drop_cnt == $past(drop_cnt) + 16'h0001) // see R12 R5
    else $error("dropped packet not counted");
  drop_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    rd_go && S_ARADDR_I == `SGQ_OFF_DROP && !drop_now |=> drop_cnt == 16'h0000 && S_RVALID_O) // see R12
    else $error("drop counter not cleared on read");
  proc_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    !(PKT_DONE_I && pkt_active) |=> proc_cnt == $past(proc_cnt)) // see R13
    else $error("processed counter moved without packet");
  short_set_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    pkt_active && empty && !PKT_DONE_I |=> shortfall) // see R1
    else $error("shortfall not raised");
  short_clr_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    PKT_DONE_I |=> !shortfall) // see R2
    else $error("shortfall not cleared at packet end");
  cur_lock_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    run && state == SGQ_IDLE && !start_fetch |=> cur == $past(cur)) // see R6
    else $error("current pointer changed while locked");
  burst_len_a: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    M_ARVALID_O |-> M_ARLEN_O == 8'(WORDS - 1) && M_ARADDR_O[5:0] == 6'h00) // see R16 R19
    else $error("descriptor burst malformed");
  cache_drive_a: assert property (@(posedge CLOCK_I) $rose(RESETN_I) |-> M_ARCACHE_O == 4'h3 && M_AWCACHE_O == 4'h3) // see R14
    else $error("cache sideband reset wrong");
endmodule

// *** sgq_mem.sv ***
// behavioural system memory answering descriptor reads on a 32-bit AXI4 read port
// assumes INCR bursts of 32-bit words, one burst at a time, word store filled by the bench
`timescale 1ns/100ps
module sgq_mem (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic [31:0] araddr_i,
  input wire logic [7:0] arlen_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic rlast_o,
  output logic rvalid_o,
  input wire logic rready_i
);
  logic [31:0] words [0:127]; // descriptors sit on 0x40-byte boundaries
  logic [6:0] ptr; // word index of the next beat
  logic [7:0] left; // beats still owed after the current one
  logic busy; // burst accepted and not finished
  logic gap; // spaces the beats out when slow_i is high
  initial foreach (words[i]) words[i] = 32'h0;
  // one burst per descriptor, beats in address order
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      arready_o <= 1'b1;
      busy <= 1'b0;
      rvalid_o <= 1'b0;
      rlast_o <= 1'b0;
      rdata_o <= 32'h0;
      gap <= 1'b0;
      ptr <= 7'h0;
      left <= 8'h0;
    end
    else
    begin
      gap <= ~gap;
      // new burst only while idle
      if (arvalid_i && arready_o)
      begin
        arready_o <= 1'b0;
        busy <= 1'b1;
        ptr <= araddr_i[8:2];
        left <= arlen_i;
      end
      // beat taken: drop the lines so a stale word is never mistaken for data
      if (rvalid_o && rready_i)
      begin
        rvalid_o <= 1'b0;
        rlast_o <= 1'b0;
        rdata_o <= ~rdata_o;
        ptr <= ptr + 7'h1;
        left <= left - 8'h1;
        if (rlast_o)
        begin
          busy <= 1'b0;
          arready_o <= 1'b1;
        end
      end
      else if (busy && !rvalid_o && (!slow_i || gap))
      begin
        rvalid_o <= 1'b1;
        rdata_o <= words[ptr];
        rlast_o <= (left == 8'h0);
      end
      else if (!rvalid_o)
        rdata_o <= ~rdata_o; // idle data toggles every cycle
    end
  end
endmodule

// *** tb_top.sv ***
// self-checking bench for the descriptor queue control block
// assumes the register map of sgq_cfg.svh and the memory model sgq_mem on the descriptor port
`timescale 1ns/100ps
`include "sgq_cfg.svh"
module tb_top;
  import sgq_pkg::*;
  logic CLOCK_I, RESETN_I, S_AWVALID_I, S_WVALID_I, S_BREADY_I, S_ARVALID_I, S_RREADY_I;
  logic [11:0] S_AWADDR_I, S_ARADDR_I;
  logic [31:0] S_WDATA_I, S_RDATA_O, M_ARADDR_O, M_RDATA_I;
  logic [3:0] S_WSTRB_I, M_ARCACHE_O, M_ARUSER_O, M_AWCACHE_O, M_AWUSER_O;
  logic [1:0] S_BRESP_O, S_RRESP_O, M_ARBURST_O;
  logic S_AWREADY_O, S_WREADY_O, S_BVALID_O, S_ARREADY_O, S_RVALID_O;
  logic [7:0] M_ARLEN_O;
  logic [2:0] M_ARSIZE_O;
  logic M_ARVALID_O, M_ARREADY_I, M_RLAST_I, M_RVALID_I, M_RREADY_O;
  sgq_desc_t DESC_O;
  logic DESC_VALID_O, DESC_DONE_I, DESC_ERR_I, PKT_ARRIVE_I, PKT_DONE_I, PKT_DROP_O;
  logic slow; // stretches the memory's answers
  int n_mismatch;
  int samples_checked;
  logic [31:0] ar_log [$]; // every descriptor burst address taken
  sgq_ctrl #(.ADDR_W(32), .APP_EN(1'b0), .IS_RX(1'b0)) dut (
    .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .S_AWADDR_I(S_AWADDR_I), .S_AWVALID_I(S_AWVALID_I),
    .S_AWREADY_O(S_AWREADY_O), .S_WDATA_I(S_WDATA_I), .S_WSTRB_I(S_WSTRB_I), .S_WVALID_I(S_WVALID_I),
    .S_WREADY_O(S_WREADY_O), .S_BRESP_O(S_BRESP_O), .S_BVALID_O(S_BVALID_O), .S_BREADY_I(S_BREADY_I),
    .S_ARADDR_I(S_ARADDR_I), .S_ARVALID_I(S_ARVALID_I), .S_ARREADY_O(S_ARREADY_O), .S_RDATA_O(S_RDATA_O),
    .S_RRESP_O(S_RRESP_O), .S_RVALID_O(S_RVALID_O), .S_RREADY_I(S_RREADY_I), .M_ARADDR_O(M_ARADDR_O),
    .M_ARLEN_O(M_ARLEN_O), .M_ARSIZE_O(M_ARSIZE_O), .M_ARBURST_O(M_ARBURST_O), .M_ARCACHE_O(M_ARCACHE_O),
    .M_ARUSER_O(M_ARUSER_O), .M_ARVALID_O(M_ARVALID_O), .M_ARREADY_I(M_ARREADY_I), .M_RDATA_I(M_RDATA_I),
    .M_RLAST_I(M_RLAST_I), .M_RVALID_I(M_RVALID_I), .M_RREADY_O(M_RREADY_O), .M_AWCACHE_O(M_AWCACHE_O),
    .M_AWUSER_O(M_AWUSER_O), .DESC_O(DESC_O), .DESC_VALID_O(DESC_VALID_O), .DESC_DONE_I(DESC_DONE_I),
    .DESC_ERR_I(DESC_ERR_I), .PKT_ARRIVE_I(PKT_ARRIVE_I), .PKT_DONE_I(PKT_DONE_I), .PKT_DROP_O(PKT_DROP_O));
  sgq_mem mem (.clk_i(CLOCK_I), .rstn_i(RESETN_I), .slow_i(slow), .araddr_i(M_ARADDR_O), .arlen_i(M_ARLEN_O),
    .arvalid_i(M_ARVALID_O), .arready_o(M_ARREADY_I), .rdata_o(M_RDATA_I), .rlast_o(M_RLAST_I),
    .rvalid_o(M_RVALID_I), .rready_i(M_RREADY_O));
  // free-running 40 MHz clock
  initial
  begin
    CLOCK_I = 1'b0;
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end
  // log burst addresses at the handshake edge
  always @(posedge CLOCK_I)
    if (RESETN_I && M_ARVALID_O && M_ARREADY_I)
      ar_log.push_back(M_ARADDR_O);
  // single comparison point; four-state compare so an unknown never matches
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a wait that ran out of its bound ends the run
  task automatic tmo;
    n_mismatch++;
    $display("BAD wait expected handshake seen none");
    conclude();
  endtask
  // lite write: both halves offered together, each dropped on its own ready
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    @(posedge CLOCK_I);
    S_AWADDR_I <= a;
    S_AWVALID_I <= 1'b1;
    S_WDATA_I <= d;
    S_WVALID_I <= 1'b1;
    S_BREADY_I <= 1'b1;
    n = 0;
    forever
    begin
      @(posedge CLOCK_I);
      n++;
      if (S_AWVALID_I && S_AWREADY_O)
        S_AWVALID_I <= 1'b0;
      if (S_WVALID_I && S_WREADY_O)
        S_WVALID_I <= 1'b0;
      if (S_BVALID_O === 1'b1)
        break;
      if (n > 40)
        tmo();
    end
    chk(S_BRESP_O, er, $sformatf("bresp %h", a));
    S_BREADY_I <= 1'b0;
  endtask
  // lite read compared under a mask; the response code is checked too
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er = 2'h0);
    int n;
    @(posedge CLOCK_I);
    S_ARADDR_I <= a;
    S_ARVALID_I <= 1'b1;
    S_RREADY_I <= 1'b1;
    n = 0;
    forever
    begin
      @(posedge CLOCK_I);
      n++;
      if (S_ARVALID_I && S_ARREADY_O)
        S_ARVALID_I <= 1'b0;
      if (S_RVALID_O === 1'b1)
        break;
      if (n > 40)
        tmo();
    end
    chk(S_RRESP_O, er, $sformatf("rresp %h", a));
    chk(S_RDATA_O & m, e, $sformatf("rdata %h", a));
    S_RREADY_I <= 1'b0;
  endtask
  // place a descriptor, buffers word aligned: next, buffer, control and side words
  task automatic mk(input int a, input logic [31:0] nx, input logic [31:0] bf);
    mem.words[a/4] = nx;
    mem.words[a/4+2] = bf;
    mem.words[a/4+5] = bf ^ 32'h8000_0040;
    mem.words[a/4+6] = ~bf;
    mem.words[a/4+7] = bf;
  endtask
  // act as the data mover: let an edge pass so the old descriptor is gone, wait, compare, complete
  task automatic serve(input logic [31:0] bf, input logic err);
    int n;
    n = 0;
    do
    begin
      @(posedge CLOCK_I);
      n++;
      if (n > 300)
        tmo();
    end
    while (DESC_VALID_O !== 1'b1);
    chk(DESC_O.buf_addr, {32'h0, bf}, "desc buf");
    chk(DESC_O.ctrl, bf ^ 32'h8000_0040, "desc ctrl");
    chk({DESC_O.word6, DESC_O.word7}, {~bf, bf}, "desc side");
    DESC_DONE_I <= 1'b1;
    DESC_ERR_I <= err;
    @(posedge CLOCK_I);
    DESC_DONE_I <= 1'b0;
    DESC_ERR_I <= 1'b0;
  endtask
  // one-cycle packet start, with the drop flag looked at in that cycle
  task automatic arrive(input logic exp);
    @(posedge CLOCK_I);
    PKT_ARRIVE_I <= 1'b1;
    @(posedge CLOCK_I);
    chk(PKT_DROP_O, exp, "drop flag");
    PKT_ARRIVE_I <= 1'b0;
  endtask
  initial
  begin
    {S_AWVALID_I, S_WVALID_I, S_BREADY_I, S_ARVALID_I, S_RREADY_I, slow} = 6'h00;
    {S_AWADDR_I, S_ARADDR_I, S_WDATA_I} = 56'h0;
    S_WSTRB_I = 4'hF;
    {DESC_DONE_I, DESC_ERR_I, PKT_ARRIVE_I, PKT_DONE_I} = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    RESETN_I = 1'b0;
    repeat (3) @(posedge CLOCK_I);
    RESETN_I <= 1'b1;
    rchk(`SGQ_OFF_STATUS, 32'h1, 32'h3);
    rchk(`SGQ_OFF_SIDEBAND, `SGQ_SB_RESET, `SGQ_SB_MASK);
    rchk(`SGQ_OFF_CUR_LO, 32'h0, 32'hFFFF_FFFF);
    rchk(`SGQ_OFF_DROP, 32'h0, 32'hFFFF);
    rchk(`SGQ_OFF_PROC, 32'h0, 32'hFFFF);
    rchk(12'h100, 32'h0, 32'h0, `SGQ_RESP_DECERR);
    wr(12'h100, 32'hFFFF_FFFF, `SGQ_RESP_DECERR);
    wr(`SGQ_OFF_CUR_HI, 32'hFFFF_FFFF);
    rchk(`SGQ_OFF_CUR_HI, 32'h0, 32'hFFFF_FFFF);
    // sideband fields land on the descriptor port while stopped
    wr(`SGQ_OFF_SIDEBAND, 32'h0A05_0C06);
    chk({M_AWUSER_O, M_AWCACHE_O, M_ARUSER_O, M_ARCACHE_O}, 16'hA5C6, "sideband pins");
    rchk(`SGQ_OFF_SIDEBAND, 32'h0A05_0C06, `SGQ_SB_MASK);
    $display("test registers done");
    // drops on an empty queue, clear on read, then a full wrap of the count
    arrive(1'b1);
    rchk(`SGQ_OFF_DROP, 32'h1, 32'hFFFF);
    rchk(`SGQ_OFF_DROP, 32'h0, 32'hFFFF);
    PKT_ARRIVE_I <= 1'b1;
    repeat (65537) @(posedge CLOCK_I);
    PKT_ARRIVE_I <= 1'b0;
    rchk(`SGQ_OFF_DROP, 32'h1, 32'hFFFF);
    $display("test drops done");
    // stopped channel: tail write moves the pause point only
    wr(`SGQ_OFF_TAIL_LO, 32'h80);
    repeat (10) @(posedge CLOCK_I);
    chk(ar_log.size(), 0, "fetch count");
    rchk(`SGQ_OFF_STATUS, 32'h1, 32'h1);
    wr(`SGQ_OFF_CUR_LO, 32'h47);
    rchk(`SGQ_OFF_CUR_LO, 32'h40, 32'hFFFF_FFC0);
    mk(32'h40, 32'h80, 32'h1000_0000);
    mk(32'h80, 32'hC0, 32'h2000_0100);
    mk(32'hC0, 32'h100, 32'h3000_0200);
    mk(32'h100, 32'h140, 32'h4000_0300);
    // running and idle: a tail write starts the walk
    wr(`SGQ_OFF_CTRL, 32'h1);
    wr(`SGQ_OFF_TAIL_LO, 32'hC0);
    rchk(`SGQ_OFF_STATUS, 32'h0, 32'h1);
    arrive(1'b0);
    serve(32'h1000_0000, 1'b0);
    serve(32'h2000_0100, 1'b0);
    wr(`SGQ_OFF_CUR_LO, 32'h200); // ignored while running
    serve(32'h3000_0200, 1'b0);
    repeat (6) @(posedge CLOCK_I);
    chk(ar_log.size(), 3, "fetch count");
    foreach (ar_log[i])
      chk(ar_log[i], 32'h40 * (i + 1), "burst address");
    rchk(`SGQ_OFF_STATUS, 32'h3, 32'h3);
    rchk(`SGQ_OFF_CUR_LO, 32'hC0, 32'hFFFF_FFC0);
    @(posedge CLOCK_I);
    PKT_DONE_I <= 1'b1;
    @(posedge CLOCK_I);
    PKT_DONE_I <= 1'b0;
    rchk(`SGQ_OFF_STATUS, 32'h1, 32'h3);
    rchk(`SGQ_OFF_PROC, 32'h1, 32'hFFFF);
    rchk(`SGQ_OFF_PROC, 32'h1, 32'hFFFF);
    $display("test walk done");
    // restart from the tail's next pointer with a slow memory, then an error short of the tail
    slow <= 1'b1;
    wr(`SGQ_OFF_TAIL_LO, 32'h140);
    serve(32'h4000_0300, 1'b1);
    repeat (10) @(posedge CLOCK_I);
    chk(ar_log.size(), 4, "fetch count");
    chk(ar_log[3], 32'h100, "burst address");
    rchk(`SGQ_OFF_CUR_LO, 32'h100, 32'hFFFF_FFC0);
    rchk(`SGQ_OFF_STATUS, 32'h0, 32'h1);
    $display("test restart done");
    conclude();
  end
endmodule
